// ===== rtl/crm_map.svh
// address map, field positions and reset values of the custom monitor register bank
`ifndef CRM_MAP_SVH
`define CRM_MAP_SVH
`define CRM_PAGE_PTR       7'h64
`define CRM_FREQ_MODE      7'h65
`define CRM_A_MULT_LO      7'h67
`define CRM_A_MULT_HI      7'h68
`define CRM_A_SCM_LO       7'h69
`define CRM_A_SCM_HI       7'h6a
`define CRM_A_CFM_LO0      7'h6b
`define CRM_A_CFM_LO1      7'h6c
`define CRM_A_CFM_HI0      7'h6d
`define CRM_A_CFM_HI1      7'h6e
`define CRM_A_CYCLES       7'h6f
`define CRM_A_DIV          7'h70
`define CRM_B_MULT_LO      7'h71
`define CRM_B_MULT_HI      7'h72
`define CRM_B_SCM_LO       7'h73
`define CRM_B_SCM_HI       7'h74
`define CRM_B_CFM_LO0      7'h75
`define CRM_B_CFM_LO1      7'h76
`define CRM_B_CFM_HI0      7'h77
`define CRM_B_CFM_HI1      7'h78
`define CRM_B_CYCLES       7'h79
`define CRM_B_DIV          7'h7a
`define CRM_PREDIV         7'h7e
`define CRM_FRO_BASE       7'h65
`define CRM_FRO_LAST       7'h68
`define CRM_SYNC1HZ        7'h71
`define CRM_RSVD_LO        7'h7b
`define CRM_PAGE_BASE      4'h0
`define CRM_PAGE_FRO       4'h1
`define CRM_PAGE_SYNC      4'h8
`define CRM_BYTE_RST       8'h00
`define CRM_MULT_HI_MASK   8'h3f
`define CRM_PAGE_MASK      8'h0f
`define CRM_MODE_REFERENCE_INPUT_ONE_LSB  2
`define CRM_MODE_REFERENCE_INPUT_TWO_LSB  4
`define CRM_NUM_BYTES      20
`endif

// ===== rtl/crm_pkg.sv
// types shared by the custom monitor register bank
package crm_pkg;
  typedef enum logic [1:0] {
    CRM_MODE_AUTO  = 2'b00,
    CRM_MODE_CUSTA = 2'b01,
    CRM_MODE_CUSTB = 2'b10,
    CRM_MODE_RSVD  = 2'b11
  } crm_mode_type;

  typedef struct packed {
    logic [13:0] multiplier;
    logic [7:0]  scm_low;
    logic [7:0]  scm_high;
    logic [15:0] cfm_low;
    logic [15:0] cfm_high;
    logic [7:0]  cycles_m1;
    logic        divide_by_four;
  } crm_profile_type;
endpackage

// ===== rtl/crm_sel_if.sv
// per-reference profile selection carried between top and selector
`timescale 1ns/1ns
interface crm_sel_if;
  crm_pkg::crm_mode_type   mode [3];
  crm_pkg::crm_profile_type prof_a;
  crm_pkg::crm_profile_type prof_b;
  crm_pkg::crm_profile_type ref_prof [3];
  logic [2:0]              ref_custom;
  modport src (output mode, output prof_a, output prof_b, input ref_prof, input ref_custom);
  modport sel (input mode, input prof_a, input prof_b, output ref_prof, output ref_custom);
endinterface

// ===== rtl/crm_ref_select.sv
// routes profile a or b to each reference according to its frequency mode
`timescale 1ns/1ns
module crm_ref_select (
  // selection bundle
  crm_sel_if.sel sel
);
  // ------------------------------------------------------------
  // per-reference profile mux
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ref
      // auto and the reserved code both fall back to auto detection
      always_comb begin
        sel.ref_prof[g]   = '0;
        sel.ref_custom[g] = 1'b0;
        unique case (sel.mode[g])
          crm_pkg::CRM_MODE_CUSTA: begin
            sel.ref_prof[g]   = sel.prof_a;
            sel.ref_custom[g] = 1'b1;
          end
          crm_pkg::CRM_MODE_CUSTB: begin
            sel.ref_prof[g]   = sel.prof_b;
            sel.ref_custom[g] = 1'b1;
          end
          default: begin
            sel.ref_prof[g]   = '0;
            sel.ref_custom[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate
endmodule

// ===== rtl/crm_regs.sv
// custom reference monitor configuration register bank
// Contract
// - profile a 14-bit multiplier, bits 13:8 at 0x68.
// - profile b multiplier low byte 0x71, bits 13:8 at 0x72.
// - each profile has single-cycle monitor low and high limits.
// - each profile has 16-bit coarse low/high limits, low byte first.
// - cycle register holds monitor cycles minus one.
// - divide control feeds reference divided by four to frequency monitors.
// - one pre-divider register controls references zero and one only.
// - four free-run offset bytes on page 1, 0x65 to 0x68.
// - 1 Hz sync detection enabled only by page 8 register 0x71.
// - extended pages reached via page pointer at 0x64.
// - frequency mode picks auto, profile a or b per reference.
// - profile a multiplier bits 7:0 at 0x67.
`timescale 1ns/1ns
`include "crm_map.svh"
module crm_regs (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  // register port from the serial host interface
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [6:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  // configuration towards the monitors
  output crm_pkg::crm_profile_type      ref_profile [3],
  output logic      [2:0]               ref_custom,
  output logic      [2:0]               ref_use_div4,
  output logic      [15:0]              ref_cycle_count [3],
  output logic      [7:0]               prescaler_ctrl,
  output logic      [31:0]              freerun_offset,
  output logic                          sync_1hz_detect_en,
  output logic      [3:0]               page_sel
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] page_q;
  logic [7:0] mode_q;
  logic [7:0] cfg_q [`CRM_NUM_BYTES];   // base page 0x67..0x7a
  logic [7:0] prediv_q;
  logic [7:0] fro_q [4];
  logic [7:0] sync_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       on_base;
  logic       on_fro;
  logic       on_sync;
  logic       in_cfg;
  logic       in_fro;
  logic [4:0] cfg_idx;
  logic [1:0] fro_idx;

  crm_sel_if sel_bus ();

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // the pointer itself is visible on every page so software can always leave
  assign on_base = (page_q[3:0] == `CRM_PAGE_BASE);
  assign on_fro  = (page_q[3:0] == `CRM_PAGE_FRO);
  assign on_sync = (page_q[3:0] == `CRM_PAGE_SYNC);
  assign in_cfg  = on_base && (reg_addr >= `CRM_A_MULT_LO) && (reg_addr <= `CRM_B_DIV);
  assign in_fro  = on_fro && (reg_addr >= `CRM_FRO_BASE) && (reg_addr <= `CRM_FRO_LAST);
  assign cfg_idx = 5'(reg_addr - `CRM_A_MULT_LO);
  assign fro_idx = 2'(reg_addr - `CRM_FRO_BASE);

  // page pointer, low nibble only, upper bits read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_q <= `CRM_BYTE_RST;
    end else if (clk_en && reg_wr && reg_addr == `CRM_PAGE_PTR) begin
      page_q <= reg_wdata & `CRM_PAGE_MASK;
    end
  end

  // frequency mode, two bits per reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= `CRM_BYTE_RST;
    end else if (clk_en && reg_wr && on_base && reg_addr == `CRM_FREQ_MODE) begin
      mode_q <= reg_wdata;
    end
  end

  // profile bytes; multiplier high bytes hold only six bits
  genvar g;
  generate
    for (g = 0; g < `CRM_NUM_BYTES; g++) begin : g_cfg
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cfg_q[g] <= `CRM_BYTE_RST;
        end else if (clk_en && reg_wr && in_cfg && cfg_idx == 5'(g)) begin
          if (g == (`CRM_A_MULT_HI - `CRM_A_MULT_LO) || g == (`CRM_B_MULT_HI - `CRM_A_MULT_LO)) begin
            cfg_q[g] <= reg_wdata & `CRM_MULT_HI_MASK;
          end else begin
            cfg_q[g] <= reg_wdata;
          end
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_fro
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          fro_q[g] <= `CRM_BYTE_RST;
        end else if (clk_en && reg_wr && in_fro && fro_idx == 2'(g)) begin
          fro_q[g] <= reg_wdata;
        end
      end
    end
  endgenerate

  // pre-divider control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prediv_q <= `CRM_BYTE_RST;
    end else if (clk_en && reg_wr && on_base && reg_addr == `CRM_PREDIV) begin
      prediv_q <= reg_wdata;
    end
  end

  // 1 Hz sync detection enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_q <= `CRM_BYTE_RST;
    end else if (clk_en && reg_wr && on_sync && reg_addr == `CRM_SYNC1HZ) begin
      sync_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped and reserved locations return zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == `CRM_PAGE_PTR) begin
      rdata_d = page_q;
    end else if (on_base && reg_addr == `CRM_FREQ_MODE) begin
      rdata_d = mode_q;
    end else if (in_cfg) begin
      rdata_d = cfg_q[cfg_idx];
    end else if (on_base && reg_addr == `CRM_PREDIV) begin
      rdata_d = prediv_q;
    end else if (in_fro) begin
      rdata_d = fro_q[fro_idx];
    end else if (on_sync && reg_addr == `CRM_SYNC1HZ) begin
      rdata_d = sync_q;
    end
  end

  // read data registered, valid the cycle after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // profile assembly and per-reference routing
  // ------------------------------------------------------------
  // offsets inside cfg_q follow the map order, a multiplier first
  always_comb begin
    sel_bus.prof_a.multiplier     = {cfg_q[1][5:0], cfg_q[0]};
    sel_bus.prof_a.scm_low        = cfg_q[2];
    sel_bus.prof_a.scm_high       = cfg_q[3];
    sel_bus.prof_a.cfm_low        = {cfg_q[5], cfg_q[4]};
    sel_bus.prof_a.cfm_high       = {cfg_q[7], cfg_q[6]};
    sel_bus.prof_a.cycles_m1      = cfg_q[8];
    sel_bus.prof_a.divide_by_four = cfg_q[9][0];
    sel_bus.prof_b.multiplier     = {cfg_q[11][5:0], cfg_q[10]};
    sel_bus.prof_b.scm_low        = cfg_q[12];
    sel_bus.prof_b.scm_high       = cfg_q[13];
    sel_bus.prof_b.cfm_low        = {cfg_q[15], cfg_q[14]};
    sel_bus.prof_b.cfm_high       = {cfg_q[17], cfg_q[16]};
    sel_bus.prof_b.cycles_m1      = cfg_q[18];
    sel_bus.prof_b.divide_by_four = cfg_q[19][0];
  end

  assign sel_bus.mode[0] = crm_pkg::crm_mode_type'(mode_q[1:0]);
  assign sel_bus.mode[1] = crm_pkg::crm_mode_type'(mode_q[`CRM_MODE_REFERENCE_INPUT_ONE_LSB +: 2]);
  assign sel_bus.mode[2] = crm_pkg::crm_mode_type'(mode_q[`CRM_MODE_REFERENCE_INPUT_TWO_LSB +: 2]);

  crm_ref_select u_sel (
    .sel (sel_bus.sel)
  );

  // monitor span is stored value plus one; div4 only for custom refs
  generate
    for (g = 0; g < 3; g++) begin : g_out
      assign ref_profile[g]     = sel_bus.ref_prof[g];
      assign ref_cycle_count[g] = {8'h00, sel_bus.ref_prof[g].cycles_m1} + 16'h0001;
      assign ref_use_div4[g]    = sel_bus.ref_custom[g] & sel_bus.ref_prof[g].divide_by_four;
    end
  endgenerate
  assign ref_custom         = sel_bus.ref_custom;
  assign prescaler_ctrl     = prediv_q;
  assign freerun_offset     = {fro_q[3], fro_q[2], fro_q[1], fro_q[0]};
  assign sync_1hz_detect_en = sync_q[0];
  assign page_sel           = page_q[3:0];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // write landing: an accepted byte shows one edge later
  // ------------------------------------------------------------
  // profiles are watched ahead of the mux so a routing fault is told apart
  // from a lost byte; masked high bytes compare against bits 5:0 only
  mult_a_high_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_A_MULT_HI
      |=> sel_bus.prof_a.multiplier[13:8] == $past(reg_wdata[5:0]))
    else $error("profile a high byte lost");
  mult_a_low_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_A_MULT_LO
      |=> sel_bus.prof_a.multiplier[7:0] == $past(reg_wdata))
    else $error("profile a low byte lost");
  mult_b_low_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_MULT_LO
      |=> sel_bus.prof_b.multiplier[7:0] == $past(reg_wdata))
    else $error("profile b low byte lost");
  mult_b_high_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_MULT_HI
      |=> sel_bus.prof_b.multiplier[13:8] == $past(reg_wdata[5:0]))
    else $error("profile b high byte lost");
  scm_limit_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_A_SCM_HI
      |=> sel_bus.prof_a.scm_high == $past(reg_wdata))
    else $error("scm high limit lost");
  scm_low_b_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_SCM_LO
      |=> sel_bus.prof_b.scm_low == $past(reg_wdata))
    else $error("profile b scm low limit lost");
  cfm_order_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_CFM_HI0
      |=> sel_bus.prof_b.cfm_high[7:0] == $past(reg_wdata))
    else $error("cfm low byte order");
  cfm_upper_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_A_CFM_LO1
      |=> sel_bus.prof_a.cfm_low[15:8] == $past(reg_wdata))
    else $error("cfm upper byte order");
  cycles_a_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_A_CYCLES
      |=> sel_bus.prof_a.cycles_m1 == $past(reg_wdata))
    else $error("profile a cycle count lost");
  div_store_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_DIV
      |=> sel_bus.prof_b.divide_by_four == $past(reg_wdata[0]))
    else $error("profile b divide flag lost");
  prescaler_set_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_PREDIV
      |=> prescaler_ctrl == $past(reg_wdata))
    else $error("prescaler write lost");
  fro_byte_a: assert property (clk_en && reg_wr && on_fro && reg_addr == `CRM_FRO_LAST
      |=> freerun_offset[31:24] == $past(reg_wdata))
    else $error("free-run byte 3");
  fro_low_a: assert property (clk_en && reg_wr && on_fro && reg_addr == `CRM_FRO_BASE
      |=> freerun_offset[7:0] == $past(reg_wdata))
    else $error("free-run byte 0");
  sync_set_a: assert property (clk_en && reg_wr && on_sync && reg_addr == `CRM_SYNC1HZ
      |=> sync_1hz_detect_en == $past(reg_wdata[0]))
    else $error("sync enable write lost");
  page_ptr_a: assert property (clk_en && reg_wr && reg_addr == `CRM_PAGE_PTR
      |=> page_sel == $past(reg_wdata[3:0]))
    else $error("page pointer");

  // ------------------------------------------------------------
  // page gating: every register but the page pointer answers on its own page only
  // ------------------------------------------------------------
  // in-page addresses repeat across pages, so a missed page term would
  // silently alias a base register onto an extended one
  prescaler_a: assert property (clk_en && reg_wr && !on_base && reg_addr == `CRM_PREDIV
      |=> $stable(prescaler_ctrl))
    else $error("prescaler on wrong page");
  sync_page_a: assert property (clk_en && reg_wr && !on_sync
      |=> $stable(sync_1hz_detect_en))
    else $error("sync enable off page");
  fro_page_a: assert property (clk_en && reg_wr && !on_fro
      |=> $stable(freerun_offset))
    else $error("free-run offset off page");
  base_gate_a: assert property (clk_en && reg_wr && !on_base
      |=> $stable(sel_bus.prof_a) && $stable(sel_bus.prof_b) && $stable(mode_q))
    else $error("base register written off page");

  // ------------------------------------------------------------
  // routing: the mode code decides what each reference sees
  // ------------------------------------------------------------
  // the reserved code must look exactly like auto detection
  cycle_span_a: assert property (clk_en && reg_wr && on_base && reg_addr == `CRM_B_CYCLES
      && sel_bus.mode[1] == crm_pkg::CRM_MODE_CUSTB
      |=> ref_cycle_count[1] == 16'($past(reg_wdata)) + 16'h0001)
    else $error("cycle span");
  div_four_a: assert property (sel_bus.mode[2] == crm_pkg::CRM_MODE_CUSTA
      |-> ref_use_div4[2] == sel_bus.prof_a.divide_by_four)
    else $error("div4 not following profile a");
  route_a_a: assert property (sel_bus.mode[2] == crm_pkg::CRM_MODE_CUSTA
      |-> ref_custom[2] && ref_profile[2] == sel_bus.prof_a)
    else $error("profile a not routed");
  mode_rsvd_a: assert property (sel_bus.mode[2] == crm_pkg::CRM_MODE_RSVD
      |-> !ref_custom[2] && !ref_use_div4[2] && ref_cycle_count[2] == 16'h0001)
    else $error("reserved mode not auto");

  // ------------------------------------------------------------
  // read path: registered data, holds until the next read
  // ------------------------------------------------------------
  // a read that leaks a neighbouring page would let software see
  // stale state after it moved the pointer
  reserved_a: assert property (clk_en && reg_rd && on_base && reg_addr == `CRM_RSVD_LO
      |=> reg_rdata == 8'h00)
    else $error("reserved not zero");
  other_page_a: assert property (clk_en && reg_rd && !on_base && !on_fro && !on_sync && reg_addr != `CRM_PAGE_PTR
      |=> reg_rdata == 8'h00)
    else $error("empty page not zero");
  page_read_a: assert property (clk_en && reg_rd && reg_addr == `CRM_PAGE_PTR
      |=> reg_rdata == 8'($past(page_sel)))
    else $error("page pointer read back");
  fro_read_a: assert property (clk_en && reg_rd && on_fro && reg_addr == `CRM_FRO_BASE
      |=> reg_rdata == $past(freerun_offset[7:0]))
    else $error("free-run read back");
  sync_read_a: assert property (clk_en && reg_rd && on_sync && reg_addr == `CRM_SYNC1HZ
      |=> reg_rdata[0] == $past(sync_1hz_detect_en))
    else $error("sync enable read back");
  read_hold_a: assert property (!(clk_en && reg_rd)
      |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // ------------------------------------------------------------
  // clock enable: a low enable freezes every register
  // ------------------------------------------------------------
  // strobes seen while frozen are dropped, not queued for later
  freeze_a: assert property (!clk_en
      |=> $stable(page_sel) && $stable(prescaler_ctrl)
          && $stable(freerun_offset) && $stable(reg_rdata))
    else $error("state moved while frozen");

  // ------------------------------------------------------------
  // coverage of the main scenarios
  // ------------------------------------------------------------
  // extended page write, sync enable, profile b divide, reserved mode, frozen strobe
  ext_page_c:  cover property (clk_en && reg_wr && on_fro && reg_addr == `CRM_FRO_BASE);
  sync_on_c:   cover property ($rose(sync_1hz_detect_en));
  cust_b_c:    cover property (sel_bus.mode[0] == crm_pkg::CRM_MODE_CUSTB && ref_use_div4[0]);
  rsvd_mode_c: cover property (sel_bus.mode[2] == crm_pkg::CRM_MODE_RSVD);
  frozen_wr_c: cover property (!clk_en && reg_wr);
endmodule

// ===== tb/crm_regs_tb.sv
// self-checking bench for the custom monitor register bank
`timescale 1ns/1ns
module crm_regs_tb;
  // ----------------------------------------
  // signals and dut
  // ----------------------------------------
  logic                     clk_sys = 1'b0;
  logic                     rst = 1'b1;
  logic                     clk_en = 1'b1;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [6:0]               reg_addr = 7'h00;
  logic [7:0]               reg_wdata = 8'h00;
  logic [7:0]               reg_rdata;
  crm_pkg::crm_profile_type ref_profile [3];
  logic [2:0]               ref_custom;
  logic [2:0]               ref_use_div4;
  logic [15:0]              ref_cycle_count [3];
  logic [7:0]               prescaler_ctrl;
  logic [31:0]              freerun_offset;
  logic                     sync_1hz_detect_en;
  logic [3:0]               page_sel;
  int                       n_mismatch = 0;
  int                       check_count = 0;

  // free-running 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  crm_regs u_dut (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .clk_en             (clk_en),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .ref_profile        (ref_profile),
    .ref_custom         (ref_custom),
    .ref_use_div4       (ref_use_div4),
    .ref_cycle_count    (ref_cycle_count),
    .prescaler_ctrl     (prescaler_ctrl),
    .freerun_offset     (freerun_offset),
    .sync_1hz_detect_en (sync_1hz_detect_en),
    .page_sel           (page_sel)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // narrower values zero-extend, so an unknown bit still mismatches
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // inputs move on the falling edge, away from the sampling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // read data is registered, settled by the following falling edge
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("reg_rdata", exp, reg_rdata);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // expected read-back of the walking pattern: bit 7 set exposes the 6-bit masks
  function automatic logic [7:0] bexp(input int a);
    if (a == 'h66 || (a >= 'h7b && a != 'h7e)) return 8'h00;
    if (a == 'h68 || a == 'h72) return 8'h3f & (8'h80 | a[7:0]);
    return 8'h80 | a[7:0];
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("page_sel", 4'h0, page_sel);
    chk("ref_custom", 3'b000, ref_custom);
    for (int i = 0; i < 3; i++) chk("cycle_count", 16'h0001, ref_cycle_count[i]);
    chk("freerun", 32'h0, {prescaler_ctrl, freerun_offset, sync_1hz_detect_en});
  endtask

  // base page from 0x66 to 0x7f, reserved holes included, written first then read
  task automatic t_readback;
    for (int a = 'h66; a <= 'h7f; a++) wr(a[6:0], 8'h80 | a[7:0]);
    for (int a = 'h66; a <= 'h7f; a++) rdchk(a[6:0], bexp(a));
  endtask

  task automatic t_profile;
    logic [7:0] tb_a [10] = '{8'h34, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'hff, 8'h01};
    logic [7:0] tb_b [10] = '{8'h78, 8'hc1, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'h00, 8'h00};
    // reference zero on profile a, one on profile b, two on code 11 falls back to auto
    wr(7'h65, 8'h39);
    for (int i = 0; i < 10; i++) wr(7'h67 + i[6:0], tb_a[i]);
    for (int i = 0; i < 10; i++) wr(7'h71 + i[6:0], tb_b[i]);
    chk("a_mult", 14'h3f34, ref_profile[0].multiplier);
    chk("a_scm", 16'h1122, {ref_profile[0].scm_low, ref_profile[0].scm_high});
    chk("a_cfm", 32'h44336655, {ref_profile[0].cfm_low, ref_profile[0].cfm_high});
    chk("a_cycles", 16'd256, ref_cycle_count[0]);
    chk("div4", 3'b001, ref_use_div4);
    chk("b_mult", 14'h0178, ref_profile[1].multiplier);
    chk("b_cfm", 32'ha4a3a6a5, {ref_profile[1].cfm_low, ref_profile[1].cfm_high});
    chk("b_cycles", 16'd1, ref_cycle_count[1]);
    chk("ref_custom", 3'b011, ref_custom);
    chk("r2_mult", 14'h0, ref_profile[2].multiplier);
    // swap: reference zero on profile b, one on auto, two on profile a
    wr(7'h65, 8'h12);
    wr(7'h7a, 8'h01);
    chk("ref_custom", 3'b101, ref_custom);
    chk("div4", 3'b101, ref_use_div4);
    chk("r0_mult", 14'h0178, ref_profile[0].multiplier);
    chk("b_scm", 16'ha1a2, {ref_profile[0].scm_low, ref_profile[0].scm_high});
    chk("r1_mult", 14'h0, ref_profile[1].multiplier);
    chk("r2_cycles", 16'd256, ref_cycle_count[2]);
  endtask

  task automatic t_pages;
    wr(7'h64, 8'h01);
    chk("page_sel", 4'h1, page_sel);
    for (int i = 0; i < 4; i++) wr(7'h65 + i[6:0], 8'(8'h11 * (i + 1)));
    chk("freerun", 32'h44332211, freerun_offset);
    wr(7'h7e, 8'h5a);
    chk("prescaler", 8'hfe, prescaler_ctrl);
    rdchk(7'h65, 8'h11);
    wr(7'h64, 8'h08);
    wr(7'h71, 8'h01);
    chk("sync_en", 1'b1, sync_1hz_detect_en);
    rdchk(7'h71, 8'h01);
    wr(7'h71, 8'h00);
    chk("sync_en", 1'b0, sync_1hz_detect_en);
    wr(7'h64, 8'h1f);
    rdchk(7'h64, 8'h0f);
    rdchk(7'h71, 8'h00);
    wr(7'h64, 8'h00);
    rdchk(7'h71, 8'h78);
    wr(7'h7e, 8'h5a);
    chk("prescaler", 8'h5a, prescaler_ctrl);
  endtask

  // a frozen clock enable must swallow the write and the read capture
  task automatic t_clk_en;
    clk_en = 1'b0;
    wr(7'h7e, 8'h00);
    rdchk(7'h7e, 8'h78);
    clk_en = 1'b1;
    chk("prescaler", 8'h5a, prescaler_ctrl);
  endtask

  // a second reset mid-run must clear every programmed register again
  task automatic t_mid_reset;
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    rdchk(7'h68, 8'h00);
    rdchk(7'h7e, 8'h00);
  endtask

  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_readback();
    t_profile();
    t_pages();
    t_clk_en();
    t_mid_reset();
    final_report();
  end

  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end
endmodule
